// >>> hw/cmils_pkg.sv
// Constants, types and register map of the charger mode and limit select
package cmils_pkg;

  localparam int CMILS_CLK_PERIOD_NS = 4;
  localparam int CMILS_DET_SETTLE_NS = 1000;
  localparam int CMILS_DET_SETTLE_CYC =
    (CMILS_DET_SETTLE_NS + CMILS_CLK_PERIOD_NS - 1) / CMILS_CLK_PERIOD_NS;
  localparam int CMILS_CNT_W = 9;

  localparam logic [7:0] CMILS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CMILS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] CMILS_ADDR_LIMIT = 8'h08;

  localparam int CMILS_CTRL_RESTART_BIT = 0;
  localparam int CMILS_CTRL_RES_ONLY_BIT = 1;
  localparam int CMILS_ST_MODE_LSB = 0;
  localparam int CMILS_ST_PINS_LSB = 4;
  localparam int CMILS_ST_DET_LSB = 8;
  localparam int CMILS_ST_SRC_LSB = 12;
  localparam int CMILS_LIM_MA_LSB = 0;
  localparam int CMILS_LIM_MV_LSB = 16;

  localparam logic [11:0] CMILS_MA_500 = 12'h1f4;
  localparam logic [11:0] CMILS_MA_1000 = 12'h3e8;
  localparam logic [11:0] CMILS_MA_1500 = 12'h5dc;
  localparam logic [11:0] CMILS_MA_2000 = 12'h7d0;
  localparam logic [11:0] CMILS_MA_2400 = 12'h960;
  localparam logic [11:0] CMILS_MA_3000 = 12'hbb8;

  // Code 0 is the open pin, code 15 the lowest resistance
  localparam logic [11:0] CMILS_INPUT_LIMIT_PIN_LUT [16] = '{
    12'h1f4, 12'h1f4, 12'h258, 12'h2bc, 12'h320, 12'h384, 12'h3e8, 12'h47e,
    12'h514, 12'h5dc, 12'h6d6, 12'h7d0, 12'h8ca, 12'h9c4, 12'ha8c, 12'hbb8};
  localparam logic [12:0] CMILS_TERMINATION_VOLTAGE_SELECT_LUT [16] = '{
    13'he10, 13'he10, 13'he74, 13'hed8, 13'hf3c, 13'hfa0, 13'h1004, 13'h1036,
    13'h1068, 13'h109a, 13'h10cc, 13'h10fe, 13'h1130, 13'h1162, 13'h1194,
    13'h11c6};

  typedef enum logic [2:0] {
    CMILS_MODE_OFF = 3'b000,
    CMILS_MODE_CHARGE = 3'b001,
    CMILS_MODE_BUCK_ONLY = 3'b010,
    CMILS_MODE_SUSPEND = 3'b011,
    CMILS_MODE_OTG = 3'b100,
    CMILS_MODE_PASSTHRU = 3'b101,
    CMILS_MODE_HALT = 3'b110
  } cmils_mode_t;

  typedef enum logic [1:0] {
    CMILS_DET_IDLE = 2'b00,
    CMILS_DET_SETTLE = 2'b01,
    CMILS_DET_DONE = 2'b10
  } cmils_det_t;

  typedef enum logic [1:0] {
    CMILS_BC_UNKNOWN = 2'b00,
    CMILS_BC_SDP = 2'b01,
    CMILS_BC_CDP = 2'b10,
    CMILS_BC_DCP = 2'b11
  } cmils_bc_t;

  typedef enum logic [2:0] {
    CMILS_PROP_NONE = 3'b000,
    CMILS_PROP_A500 = 3'b001,
    CMILS_PROP_A1000 = 3'b010,
    CMILS_PROP_A2000 = 3'b011,
    CMILS_PROP_A2400 = 3'b100,
    CMILS_PROP_B2000 = 3'b101
  } cmils_prop_t;

  typedef enum logic [1:0] {
    CMILS_CC_NONE = 2'b00,
    CMILS_CC_500 = 2'b01,
    CMILS_CC_1500 = 2'b10,
    CMILS_CC_3000 = 2'b11
  } cmils_cc_t;

  typedef enum logic [2:0] {
    CMILS_SRC_NONE = 3'b000,
    CMILS_SRC_BC = 3'b001,
    CMILS_SRC_PROP = 3'b010,
    CMILS_SRC_CC = 3'b011,
    CMILS_SRC_RES = 3'b100
  } cmils_src_t;

endpackage : cmils_pkg

// >>> hw/cmils_top.sv
// Pin mode decode, input limit and termination voltage select with APB
`timescale 1ns/1ps
`default_nettype none

module cmils_top (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_charge_disable_in,
  input wire logic i_suspend_in,
  input wire logic i_boost_enable_in,
  input wire logic i_charger_input_valid,
  input wire logic i_source_present,
  input wire logic i_battery_present,
  input wire logic i_data_lines_open,
  input wire logic [1:0] i_bc_type,
  input wire logic [2:0] i_prop_type,
  input wire logic [1:0] i_cc_adv,
  input wire logic [3:0] i_input_limit_pin_code,
  input wire logic [3:0] i_termination_voltage_select,
  output logic o_buck_on,
  output logic o_boost_on,
  output logic o_charging_on,
  output logic o_battery_switch_on,
  output logic o_charger_input_fet_on,
  output logic o_passthrough_switch_on,
  output logic o_cc_rd_connect,
  output logic o_cc_source_current_on,
  output logic o_detect_done,
  output logic [11:0] o_input_limit_ma,
  output logic [12:0] o_termination_mv
);

  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic cd_s;
  logic susp_s;
  logic boost_s;
  logic boost_ok;
  cmils_pkg::cmils_mode_t mode;
  cmils_pkg::cmils_mode_t next_mode;
  cmils_pkg::cmils_det_t det_state;
  cmils_pkg::cmils_det_t next_det_state;
  logic [cmils_pkg::CMILS_CNT_W-1:0] det_cnt;
  cmils_pkg::cmils_src_t det_src;
  cmils_pkg::cmils_src_t next_src;
  logic [11:0] det_ma;
  logic [11:0] next_det_ma;
  logic [11:0] next_limit_ma;
  logic res_only;
  logic restart;
  logic valid_d;
  logic [31:0] rd_mux;
  logic rd_err;
  logic wr_en;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {i_charge_disable_in, i_suspend_in, i_boost_enable_in};
      pin_sync <= pin_meta;
    end
  end

  // Undriven pins resolve low via the pin pulldowns
  assign cd_s = pin_sync[2];
  assign susp_s = pin_sync[1];
  assign boost_s = pin_sync[0];
  // Boost allowed only from battery with input free
  assign boost_ok = !i_source_present && i_battery_present;

  always_comb begin
    next_mode = cmils_pkg::CMILS_MODE_OFF;
    // Disabled charge plus boost halts both converters
    if (cd_s && boost_s) begin
      next_mode = cmils_pkg::CMILS_MODE_HALT;
    end else if (!cd_s && boost_s) begin
      if (!boost_ok) begin
        next_mode = cmils_pkg::CMILS_MODE_HALT;
      end else if (susp_s) begin
        next_mode = cmils_pkg::CMILS_MODE_PASSTHRU;
      end else begin
        next_mode = cmils_pkg::CMILS_MODE_OTG;
      end
    // Buck modes need a valid input
    end else if (i_charger_input_valid) begin
      if (susp_s) begin
        next_mode = cmils_pkg::CMILS_MODE_SUSPEND;
      end else if (cd_s) begin
        next_mode = cmils_pkg::CMILS_MODE_BUCK_ONLY;
      end else begin
        next_mode = cmils_pkg::CMILS_MODE_CHARGE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode <= cmils_pkg::CMILS_MODE_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // Power switch outputs, registered to avoid decode glitches
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_buck_on <= 1'b0;
      o_boost_on <= 1'b0;
      o_charging_on <= 1'b0;
      o_battery_switch_on <= 1'b0;
      o_charger_input_fet_on <= 1'b0;
      o_passthrough_switch_on <= 1'b0;
    end else begin
      o_buck_on <= (next_mode == cmils_pkg::CMILS_MODE_CHARGE) ||
                   (next_mode == cmils_pkg::CMILS_MODE_BUCK_ONLY);
      // Source role powers the input pin
      o_boost_on <= (next_mode == cmils_pkg::CMILS_MODE_OTG) ||
                    (next_mode == cmils_pkg::CMILS_MODE_PASSTHRU);
      o_charging_on <= (next_mode == cmils_pkg::CMILS_MODE_CHARGE);
      o_battery_switch_on <= !cd_s;
      o_charger_input_fet_on <= !susp_s;
      o_passthrough_switch_on <= (next_mode == cmils_pkg::CMILS_MODE_OTG);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cc_source_current_on <= 1'b0;
      o_cc_rd_connect <= 1'b1;
    end else begin
      o_cc_source_current_on <= boost_s;
      o_cc_rd_connect <= !boost_s;
    end
  end

  // Detection restarts on each new input so a swapped cable is reclassified
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_d <= 1'b0;
    end else begin
      valid_d <= i_charger_input_valid;
    end
  end

  a_detect_starts: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (!valid_d && i_charger_input_valid && !restart)
    |=> det_state == cmils_pkg::CMILS_DET_SETTLE)
    else $error("detection did not start on new input");

  always_comb begin
    next_det_state = det_state;
    if (!i_charger_input_valid || restart) begin
      next_det_state = cmils_pkg::CMILS_DET_IDLE;
    end else begin
      case (det_state)
        cmils_pkg::CMILS_DET_IDLE: begin
          next_det_state = cmils_pkg::CMILS_DET_SETTLE;
        end
        cmils_pkg::CMILS_DET_SETTLE: begin
          if (det_cnt == cmils_pkg::CMILS_CNT_W'(
              cmils_pkg::CMILS_DET_SETTLE_CYC - 1)) begin
            next_det_state = cmils_pkg::CMILS_DET_DONE;
          end
        end
        default: begin
          next_det_state = cmils_pkg::CMILS_DET_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      det_state <= cmils_pkg::CMILS_DET_IDLE;
    end else begin
      det_state <= next_det_state;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      det_cnt <= '0;
    end else if (det_state == cmils_pkg::CMILS_DET_SETTLE) begin
      det_cnt <= det_cnt + cmils_pkg::CMILS_CNT_W'(1);
    end else begin
      det_cnt <= '0;
    end
  end

  // Classification priority: CC above 500 mA, then proprietary, then BC
  always_comb begin
    next_src = cmils_pkg::CMILS_SRC_RES;
    next_det_ma = cmils_pkg::CMILS_MA_500;
    if (i_cc_adv == cmils_pkg::CMILS_CC_3000) begin
      next_src = cmils_pkg::CMILS_SRC_CC;
      next_det_ma = cmils_pkg::CMILS_MA_3000;
    end else if (i_cc_adv == cmils_pkg::CMILS_CC_1500) begin
      next_src = cmils_pkg::CMILS_SRC_CC;
      next_det_ma = cmils_pkg::CMILS_MA_1500;
    // Open data lines fall back to the resistor
    end else if (i_data_lines_open) begin
      next_src = cmils_pkg::CMILS_SRC_RES;
    end else if (i_prop_type != cmils_pkg::CMILS_PROP_NONE) begin
      next_src = cmils_pkg::CMILS_SRC_PROP;
      case (i_prop_type)
        cmils_pkg::CMILS_PROP_A500: next_det_ma = cmils_pkg::CMILS_MA_500;
        cmils_pkg::CMILS_PROP_A1000: next_det_ma = cmils_pkg::CMILS_MA_1000;
        cmils_pkg::CMILS_PROP_A2400: next_det_ma = cmils_pkg::CMILS_MA_2400;
        default: next_det_ma = cmils_pkg::CMILS_MA_2000;
      endcase
    end else if (i_bc_type != cmils_pkg::CMILS_BC_UNKNOWN) begin
      next_src = cmils_pkg::CMILS_SRC_BC;
      if (i_bc_type == cmils_pkg::CMILS_BC_SDP) begin
        next_det_ma = cmils_pkg::CMILS_MA_500;
      end else begin
        next_det_ma = cmils_pkg::CMILS_MA_1500;
      end
    end else if (i_cc_adv == cmils_pkg::CMILS_CC_500) begin
      next_src = cmils_pkg::CMILS_SRC_CC;
      next_det_ma = cmils_pkg::CMILS_MA_500;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      det_src <= cmils_pkg::CMILS_SRC_NONE;
      det_ma <= cmils_pkg::CMILS_MA_500;
    end else if (!i_charger_input_valid) begin
      det_src <= cmils_pkg::CMILS_SRC_NONE;
      det_ma <= cmils_pkg::CMILS_MA_500;
    end else if (det_state == cmils_pkg::CMILS_DET_SETTLE &&
                 next_det_state == cmils_pkg::CMILS_DET_DONE) begin
      det_src <= next_src;
      det_ma <= next_det_ma;
    end
  end

  always_comb begin
    if (det_src == cmils_pkg::CMILS_SRC_NONE) begin
      next_limit_ma = cmils_pkg::CMILS_MA_500;
    end else if (det_src == cmils_pkg::CMILS_SRC_RES || res_only) begin
      next_limit_ma = cmils_pkg::CMILS_INPUT_LIMIT_PIN_LUT[i_input_limit_pin_code];
    end else begin
      next_limit_ma = det_ma;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_input_limit_ma <= cmils_pkg::CMILS_MA_500;
      o_termination_mv <= cmils_pkg::CMILS_TERMINATION_VOLTAGE_SELECT_LUT[0];
      o_detect_done <= 1'b0;
    end else begin
      o_input_limit_ma <= next_limit_ma;
      o_termination_mv <=
        cmils_pkg::CMILS_TERMINATION_VOLTAGE_SELECT_LUT[i_termination_voltage_select];
      o_detect_done <= (det_state == cmils_pkg::CMILS_DET_DONE);
    end
  end

  // APB slave, zero wait states; read data staged in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    if (paddr == cmils_pkg::CMILS_ADDR_CTRL) begin
      rd_mux[cmils_pkg::CMILS_CTRL_RES_ONLY_BIT] = res_only;
    end else if (paddr == cmils_pkg::CMILS_ADDR_STATUS) begin
      rd_mux[cmils_pkg::CMILS_ST_MODE_LSB +: 3] = mode;
      rd_mux[cmils_pkg::CMILS_ST_PINS_LSB +: 3] = pin_sync;
      rd_mux[cmils_pkg::CMILS_ST_DET_LSB +: 2] = det_state;
      rd_mux[cmils_pkg::CMILS_ST_SRC_LSB +: 3] = det_src;
    end else if (paddr == cmils_pkg::CMILS_ADDR_LIMIT) begin
      rd_mux[cmils_pkg::CMILS_LIM_MA_LSB +: 12] = o_input_limit_ma;
      rd_mux[cmils_pkg::CMILS_LIM_MV_LSB +: 13] = o_termination_mv;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= rd_err;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_only <= 1'b0;
      restart <= 1'b0;
    end else begin
      restart <= wr_en && paddr == cmils_pkg::CMILS_ADDR_CTRL &&
                 pwdata[cmils_pkg::CMILS_CTRL_RESTART_BIT];
      if (wr_en && paddr == cmils_pkg::CMILS_ADDR_CTRL) begin
        res_only <= pwdata[cmils_pkg::CMILS_CTRL_RES_ONLY_BIT];
      end
    end
  end

  a_cd_no_charge: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    cd_s |=> !o_charging_on && !o_battery_switch_on)
    else $error("charging while charge disabled");

  a_suspend_buck_off: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) susp_s |=> !o_buck_on && !o_charger_input_fet_on)
    else $error("buck or input FET on in suspend");

  a_otg_switch_closed: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (boost_s && !susp_s && !cd_s && boost_ok)
    |=> o_boost_on && o_passthrough_switch_on)
    else $error("cable boost not entered");

  a_cc_advert_on: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_cc_source_current_on == $past(i_boost_enable_in, 3) &&
    o_cc_rd_connect != o_cc_source_current_on)
    else $error("CC advertisement wrong");

  a_passthru_boost: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (boost_s && susp_s && !cd_s && boost_ok)
    |=> o_boost_on && !o_passthrough_switch_on)
    else $error("passthrough boost wrong");

  a_cd_boost_halt: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (cd_s && boost_s) |=> !o_buck_on && !o_boost_on)
    else $error("converter on with disable and boost");

  a_boost_gated: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !boost_ok |=> !o_boost_on)
    else $error("boost with source or no battery");

  a_resistor_limit: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (det_src == cmils_pkg::CMILS_SRC_RES)
    |=> o_input_limit_ma ==
        cmils_pkg::CMILS_INPUT_LIMIT_PIN_LUT[$past(i_input_limit_pin_code)])
    else $error("unknown adapter not on resistor limit");

  a_detect_settles: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) (det_state == cmils_pkg::CMILS_DET_SETTLE &&
    i_charger_input_valid && !restart)[*1] ##0
    ($past(det_state) == cmils_pkg::CMILS_DET_IDLE)
    |-> ##[1:300] (det_state != cmils_pkg::CMILS_DET_SETTLE))
    else $error("detection never completes");

endmodule : cmils_top

`default_nettype wire

// >>> dv/cmils_adapter_model.sv
// Behavioural cable-side adapter feeding the detection inputs
`timescale 1ns/1ps
`default_nettype none
module cmils_adapter_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_attach,
  input wire logic i_src,
  input wire logic i_open,
  input wire logic [1:0] i_bc,
  input wire logic [2:0] i_prop,
  input wire logic [1:0] i_cc,
  output logic o_valid,
  output logic o_source_present,
  output logic o_data_lines_open,
  output logic [1:0] o_bc,
  output logic [2:0] o_prop,
  output logic [1:0] o_cc
);
  // Unplugged lines toggle so a stale class cannot pass for a real one
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_source_present <= 1'b0;
      o_data_lines_open <= 1'b0;
      o_bc <= 2'h0;
      o_prop <= 3'h0;
      o_cc <= 2'h0;
    end else if (i_attach) begin
      o_valid <= 1'b1;
      o_source_present <= i_src;
      o_data_lines_open <= i_open;
      o_bc <= i_bc;
      o_prop <= i_prop;
      o_cc <= i_cc;
    end else begin
      o_valid <= 1'b0;
      o_source_present <= 1'b0;
      o_data_lines_open <= ~o_data_lines_open;
      o_bc <= ~o_bc;
      o_prop <= ~o_prop;
      o_cc <= ~o_cc;
    end
  end
endmodule : cmils_adapter_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the charger mode and input limit select
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_ref_clk, i_nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cd, b, s, bat, att, src, opn, e, valid, srcp, dlo, rdc, scur, done;
  logic [1:0] bc, cc, bco, cco;
  logic [2:0] prop, propo;
  logic [3:0] rcode, vcode;
  logic [5:0] sw, ex;
  logic [11:0] ma;
  logic [12:0] mv;
  logic bk, bs, cg, bw, ft, ps;
  int err_total, n_compared;
  localparam logic [11:0] LMA [16] = '{12'h1f4, 12'h1f4, 12'h258, 12'h2bc,
    12'h320, 12'h384, 12'h3e8, 12'h47e, 12'h514, 12'h5dc, 12'h6d6, 12'h7d0,
    12'h8ca, 12'h9c4, 12'ha8c, 12'hbb8};
  localparam logic [12:0] LMV [16] = '{13'he10, 13'he10, 13'he74, 13'hed8,
    13'hf3c, 13'hfa0, 13'h1004, 13'h1036, 13'h1068, 13'h109a, 13'h10cc,
    13'h10fe, 13'h1130, 13'h1162, 13'h1194, 13'h11c6};
  // Adapter class {open, bc, prop, cc} and the limit it earns
  localparam logic [7:0] KIN [13] = '{8'h20, 8'h40, 8'h60, 8'h04, 8'h08,
    8'h0c, 8'h10, 8'h14, 8'h01, 8'h02, 8'h03, 8'h00, 8'he0};
  localparam logic [11:0] KMA [13] = '{12'h1f4, 12'h5dc, 12'h5dc, 12'h1f4,
    12'h3e8, 12'h7d0, 12'h960, 12'h7d0, 12'h1f4, 12'h5dc, 12'hbb8, 12'h8ca,
    12'h8ca};
  assign sw = {bk, bs, cg, bw, ft, ps};
  cmils_top dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_charge_disable_in(cd), .i_suspend_in(s), .i_boost_enable_in(b),
    .i_charger_input_valid(valid), .i_source_present(srcp),
    .i_battery_present(bat), .i_data_lines_open(dlo), .i_bc_type(bco),
    .i_prop_type(propo), .i_cc_adv(cco), .i_input_limit_pin_code(rcode),
    .i_termination_voltage_select(vcode), .o_buck_on(bk), .o_boost_on(bs),
    .o_charging_on(cg), .o_battery_switch_on(bw),
    .o_charger_input_fet_on(ft), .o_passthrough_switch_on(ps),
    .o_cc_rd_connect(rdc), .o_cc_source_current_on(scur),
    .o_detect_done(done), .o_input_limit_ma(ma), .o_termination_mv(mv));
  cmils_adapter_model adp_u (.i_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_attach(att), .i_src(src), .i_open(opn), .i_bc(bc), .i_prop(prop),
    .i_cc(cc), .o_valid(valid), .o_source_present(srcp),
    .o_data_lines_open(dlo), .o_bc(bco), .o_prop(propo), .o_cc(cco));
  always #2 i_ref_clk = ~i_ref_clk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task final_report;
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // Waits on pready as long as it takes; the watchdog bounds a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task pins(input logic [2:0] v, input int w);
    @(posedge i_ref_clk);
    {cd, b, s} <= v;
    repeat (w) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask : pins
  task det(input logic [7:0] k);
    @(posedge i_ref_clk);
    att <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    {opn, bc, prop, cc} <= k;
    att <= 1'b1;
    while (done !== 1'b1) begin
      @(posedge i_ref_clk);
    end
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(32'(done), 32'h1);
  endtask : det
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    err_total++;
    final_report();
  end
  initial begin
    i_ref_clk = 0; i_nrst = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; cd = 0; b = 0; s = 0; bat = 1;
    att = 0; src = 0; opn = 0; bc = 2'h0; cc = 2'h0; prop = 3'h0;
    rcode = 4'h0; vcode = 4'h0; err_total = 0; n_compared = 0;
    repeat (9) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(32'({rdc, ma, mv, sw}), 32'({1'b1, 12'h1f4, 13'he10, 6'h0}));
    @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    att <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      pins(3'(i), 5);
      ex = {!b && !s, !cd && b, !cd && !b && !s, !cd, !s, !cd && b && !s};
      chk(32'(sw), 32'(ex));
      chk(32'({rdc, scur}), 32'({!b, b}));
      if (!cd) begin
        apb(1'b0, cmils_pkg::CMILS_ADDR_STATUS, 32'h0);
        ex = {3'h0, b ? (s ? 3'h5 : 3'h4) : (s ? 3'h3 : 3'h1)};
        chk(32'({rd[6:4], rd[2:0]}), 32'({cd, s, b, ex[2:0]}));
      end
    end
    // Pin change shows after exactly three edges
    pins(3'h0, 2);
    chk(32'(bk), 32'h0);
    @(negedge i_ref_clk);
    chk(32'(bk), 32'h1);
    @(posedge i_ref_clk);
    src <= 1'b1;
    pins(3'h2, 5);
    chk(32'({bs, ps}), 32'h0);
    apb(1'b0, cmils_pkg::CMILS_ADDR_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'h6);
    @(posedge i_ref_clk);
    src <= 1'b0;
    bat <= 1'b0;
    pins(3'h2, 5);
    chk(32'({bs, ps}), 32'h0);
    @(posedge i_ref_clk);
    bat <= 1'b1;
    pins(3'h2, 5);
    chk(32'({bs, ps}), 32'h3);
    @(posedge i_ref_clk);
    att <= 1'b0;
    pins(3'h0, 6);
    chk(32'({bk, cg, bw, ma}), 32'({3'h1, 12'h1f4}));
    @(posedge i_ref_clk);
    rcode <= 4'hc;
    vcode <= 4'h9;
    for (int k = 0; k < 13; k++) begin
      det(KIN[k]);
      chk(32'(ma), 32'(KMA[k]));
    end
    det(8'h60);
    apb(1'b1, cmils_pkg::CMILS_ADDR_CTRL, 32'h2);
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(32'(ma), 32'h8ca);
    apb(1'b0, cmils_pkg::CMILS_ADDR_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, cmils_pkg::CMILS_ADDR_LIMIT, 32'h0);
    chk(32'(e), 32'h0);
    chk(rd, {3'h0, 13'h109a, 4'h0, 12'h8ca});
    apb(1'b0, 8'h0c, 32'h0);
    chk(32'(e), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, cmils_pkg::CMILS_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(32'(ma), 32'h5dc);
    det(8'h00);
    for (int c = 0; c < 16; c++) begin
      @(posedge i_ref_clk);
      rcode <= 4'(c);
      vcode <= 4'(c);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      chk(32'({ma, mv}), 32'({LMA[c], LMV[c]}));
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
